// file: rtl/rdp_pkg.sv
// Constants and types for the radio event and data port.
// Assumes one synchronous system clock and an 8-bit SFR port.
// Notes on behaviour
// - Eight event flags, underflow down to sync.
// - Flags reset zero; write zero clears only.
// - Eight-bit mask, same order, resets zero.
// - Packet done also on underflow or overflow.
// - One data byte register serves both directions.
// - Byte arriving while one is unread: overflow, old byte kept, two flags set.
// - Too few transmit bytes: underflow, two flags.
// - No byte after strobe: keep sending preamble.
// - Only idle strobe leaves overflow or underflow.
// - Data register lost in deepest sleep.
// - Rate is (256+mantissa)*2^exp/2^28 of clock.
// - Same rate setting for transmit and receive.
// - Symbol rate capped by system clock division.
// - Masked pending flag raises CPU radio flag.
// - Flags set on rising condition edge only.
// - Byte request flag; in receive when a byte is held, for transmit never before the strobe.
package rdp_pkg;
	localparam logic [7:0] ADDR_MASK = 8'h91;
	localparam logic [7:0] ADDR_FLAGS = 8'hE9;
	localparam logic [7:0] ADDR_DATA = 8'hD9;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam int BIT_TXUNF = 7;
	localparam int BIT_RXOVF = 6;
	localparam int BIT_TIMEOUT = 5;
	localparam int BIT_DONE = 4;
	localparam int BIT_CS = 3;
	localparam int BIT_PQT = 2;
	localparam int BIT_CCA = 1;
	localparam int BIT_SFD = 0;
	localparam int RATE_FRAC_BITS = 28;
	localparam logic [8:0] RATE_BASE = 9'h100;
	localparam logic [2:0] LAST_SYMBOL = 3'h7;
	localparam int MIN_SYMBOL_CYCLES = 4;
	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_RX      = 3'b001,
		ST_TX_WAIT = 3'b010,
		ST_TX      = 3'b011,
		ST_RX_OVF  = 3'b100,
		ST_TX_UNF  = 3'b101
	} rdp_state_type;
endpackage

// file: rtl/rdp_rate_gen.sv
// Symbol tick generator from mantissa and exponent.
// Assumes the reference frequency equals the system clock.
`timescale 1ns/10ps
`default_nettype none
module rdp_rate_gen #(
	parameter int MIN_CYCLES = rdp_pkg::MIN_SYMBOL_CYCLES
) (
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	input  wire logic       run,
	input  wire logic [7:0] mantissa,
	input  wire logic [3:0] exponent,
	input  wire logic [2:0] clk_speed,
	output logic            tick
);
	import rdp_pkg::*;
	logic [RATE_FRAC_BITS-1:0] acc;
	logic [RATE_FRAC_BITS:0]   sum;
	logic [23:0]               step;
	logic [10:0]               gap;
	logic [10:0]               limit;
	logic                      pending;

	//////////////////////////////////////////////////////////////////////
	// A carry out of the 28-bit accumulator is one symbol.
	// Each clock adds (256 + mantissa) << exponent, so the carry rate
	// is that step over two to the 28th of the clock.
	assign step = 24'(RATE_BASE + {1'b0, mantissa}) << exponent;
	assign sum = {1'b0, acc} + {5'h00, step};
	// A slower system clock stretches the least symbol spacing.
	assign limit = 11'(MIN_CYCLES) << clk_speed;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			acc <= '0;
		end else if (!run) begin
			acc <= '0;
		end else begin
			acc <= sum[RATE_FRAC_BITS-1:0];
		end
	end

	// Carries that arrive too early wait, so the rate saturates.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pending <= 1'b0;
			gap <= '0;
			tick <= 1'b0;
		end else begin
			tick <= 1'b0;
			if (gap != 11'h7FF) begin
				gap <= gap + 11'h001;
			end
			if (!run) begin
				pending <= 1'b0;
			end else if ((pending || sum[RATE_FRAC_BITS]) &&
					gap >= limit) begin
				tick <= 1'b1;
				gap <= 11'h001;
				pending <= 1'b0;
			end else if (sum[RATE_FRAC_BITS]) begin
				pending <= 1'b1;
			end
		end
	end

	property p_rate_cap;
		@(posedge sys_clk) disable iff (sys_rst)
		tick |=> !tick [*3];
	endproperty
	a_rate_cap: assert property (p_rate_cap)
		else $error("Symbol ticks closer than the cap.");
endmodule
`default_nettype wire

// file: rtl/rdp_radio_port.sv
// Radio event flags, mask and shared data byte register.
// Assumes the command strobe machine, modem and packet handler
// drive the strobes and status conditions synchronously.
`timescale 1ns/10ps
`default_nettype none
module rdp_radio_port (
	input  wire logic                sys_clk,
	input  wire logic                sys_rst,
	input  wire logic [7:0]          sfr_addr,
	input  wire logic                sfr_wr,
	input  wire logic                sfr_rd,
	input  wire logic [7:0]          sfr_wdata,
	output logic [7:0]               sfr_rdata,
	input  wire logic                transmit_strobe,
	input  wire logic                receive_strobe,
	input  wire logic                idle_strobe,
	input  wire logic                deep_sleep,
	input  wire logic [7:0]          rate_mantissa,
	input  wire logic [3:0]          rate_exponent,
	input  wire logic [2:0]          clk_speed,
	input  wire logic                rx_byte_valid,
	input  wire logic [7:0]          rx_byte,
	input  wire logic                cond_timeout,
	input  wire logic                cond_packet_end,
	input  wire logic                cond_carrier,
	input  wire logic                cond_preamble,
	input  wire logic                cond_clear_channel,
	input  wire logic                cond_sync,
	output logic [7:0]               tx_byte,
	output logic                     tx_byte_take,
	output logic                     symbol_tick,
	output logic                     radio_byte_request_flag,
	output logic                     cpu_radio_irq_flag,
	output rdp_pkg::rdp_state_type   radio_state
);
	import rdp_pkg::*;
	logic [7:0]    radio_event_flags;
	logic [7:0]    radio_event_mask;
	logic [7:0]    radio_data_byte;
	logic          data_full;
	logic [5:0]    cond_prev;
	logic [5:0]    cond_now;
	logic [5:0]    cond_rise;
	logic [7:0]    ev_set;
	logic [7:0]    next_flags;
	logic [2:0]    sym_cnt;
	logic          byte_tick;
	logic          wr_mask;
	logic          wr_flags;
	logic          wr_data;
	logic          rd_data;
	logic          enter_ovf;
	logic          enter_unf;
	logic          tx_taking;
	logic          rate_run;
	rdp_state_type state;
	rdp_state_type next_state;

	assign radio_state = state;
	assign wr_mask = sfr_wr && sfr_addr == ADDR_MASK;
	assign wr_flags = sfr_wr && sfr_addr == ADDR_FLAGS;
	assign wr_data = sfr_wr && sfr_addr == ADDR_DATA;
	assign rd_data = sfr_rd && sfr_addr == ADDR_DATA;
	//////////////////////////////////////////////////////////////////////
	// One rate setting drives both directions.
	assign rate_run = state == ST_RX || state == ST_TX ||
		state == ST_TX_WAIT;

	rdp_rate_gen u_rate (
		.sys_clk   (sys_clk),
		.sys_rst   (sys_rst),
		.run       (rate_run),
		.mantissa  (rate_mantissa),
		.exponent  (rate_exponent),
		.clk_speed (clk_speed),
		.tick      (symbol_tick)
	);

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sym_cnt <= '0;
		end else if (state != ST_TX && state != ST_TX_WAIT) begin
			sym_cnt <= '0;
		end else if (symbol_tick) begin
			sym_cnt <= sym_cnt + 3'h1;
		end
	end
	assign byte_tick = symbol_tick && sym_cnt == LAST_SYMBOL;

	//////////////////////////////////////////////////////////////////////
	// Byte flow state machine.
	assign enter_ovf = state == ST_RX && rx_byte_valid && data_full;
	assign enter_unf = state == ST_TX && byte_tick && !data_full &&
		!cond_packet_end;
	assign tx_taking = (state == ST_TX || state == ST_TX_WAIT) &&
		byte_tick && data_full;

	always_comb begin
		unique case (state)
			ST_IDLE: next_state = transmit_strobe ? ST_TX_WAIT :
				(receive_strobe ? ST_RX : ST_IDLE);
			ST_RX: next_state = idle_strobe ? ST_IDLE :
				(enter_ovf ? ST_RX_OVF : ST_RX);
			// An empty slot here only lengthens the preamble.
			ST_TX_WAIT: next_state = idle_strobe ? ST_IDLE :
				(tx_taking ? ST_TX : ST_TX_WAIT);
			ST_TX: next_state =
				(idle_strobe || cond_rise[BIT_DONE]) ? ST_IDLE :
				(enter_unf ? ST_TX_UNF : ST_TX);
			ST_RX_OVF, ST_TX_UNF: next_state =
				idle_strobe ? ST_IDLE : state;
			default: next_state = ST_IDLE;
		endcase
	end
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end
	//////////////////////////////////////////////////////////////////////
	// Shared data byte: CPU writes feed transmit, reads drain receive.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			radio_data_byte <= RESET_BYTE;
			data_full <= 1'b0;
		end else if (deep_sleep) begin
			radio_data_byte <= RESET_BYTE;
			data_full <= 1'b0;
		end else if (state == ST_RX) begin
			if (rx_byte_valid && !data_full) begin
				radio_data_byte <= rx_byte;
				data_full <= 1'b1;
			end else if (rd_data) begin
				data_full <= 1'b0;
			end
		end else if (state == ST_TX || state == ST_TX_WAIT) begin
			if (wr_data && !data_full) begin
				radio_data_byte <= sfr_wdata;
				data_full <= 1'b1;
			end else if (tx_taking) begin
				data_full <= 1'b0;
			end
		end else begin
			data_full <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_byte <= RESET_BYTE;
			tx_byte_take <= 1'b0;
		end else begin
			tx_byte_take <= tx_taking;
			if (tx_taking) begin
				tx_byte <= radio_data_byte;
			end
		end
	end

	// Writes before the transmit strobe are dropped, as no request shows.
	always_comb begin
		unique case (state)
			ST_RX: radio_byte_request_flag = data_full;
			ST_TX_WAIT, ST_TX: radio_byte_request_flag = !data_full;
			default: radio_byte_request_flag = 1'b0;
		endcase
	end

	//////////////////////////////////////////////////////////////////////
	// Event flags. Conditions are edge detected so a held level
	// cannot refire after software clears its flag.
	assign cond_now = {cond_timeout, cond_packet_end, cond_carrier,
		cond_preamble, cond_clear_channel, cond_sync};
	assign cond_rise = cond_now & ~cond_prev;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cond_prev <= '0;
		end else begin
			cond_prev <= cond_now;
		end
	end

	always_comb begin
		ev_set = {2'b00, cond_rise};
		ev_set[BIT_TXUNF] = enter_unf;
		ev_set[BIT_RXOVF] = enter_ovf;
		ev_set[BIT_DONE] = cond_rise[4] || enter_unf || enter_ovf;
		next_flags = radio_event_flags;
		if (wr_flags) begin
			next_flags = radio_event_flags & sfr_wdata;
		end
		next_flags = next_flags | ev_set;
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			radio_event_flags <= RESET_BYTE;
		end else begin
			radio_event_flags <= next_flags;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			radio_event_mask <= RESET_BYTE;
		end else if (wr_mask) begin
			radio_event_mask <= sfr_wdata;
		end
	end

	assign cpu_radio_irq_flag =
		|(radio_event_flags & radio_event_mask);
	//////////////////////////////////////////////////////////////////////
	// Read data is registered; unmapped addresses read zero.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sfr_rdata <= RESET_BYTE;
		end else if (sfr_rd) begin
			unique case (sfr_addr)
				ADDR_MASK: sfr_rdata <= radio_event_mask;
				ADDR_FLAGS: sfr_rdata <= radio_event_flags;
				ADDR_DATA: sfr_rdata <= radio_data_byte;
				default: sfr_rdata <= RESET_BYTE;
			endcase
		end
	end
	//////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	property p_flag_clear;
		wr_flags && ev_set == 8'h00 |=>
			radio_event_flags == $past(radio_event_flags & sfr_wdata);
	endproperty
	a_flag_clear: assert property (p_flag_clear)
		else $error("Flag write did not clear as written.");
	property p_set_wins;
		ev_set != 8'h00 |=> (radio_event_flags & $past(ev_set)) ==
			$past(ev_set);
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("Event lost against a flag clear.");
	// A new event under its mask must reach the CPU flag next cycle.
	property p_irq;
		(ev_set & radio_event_mask) != 8'h00 && !wr_mask |=>
			cpu_radio_irq_flag;
	endproperty
	a_irq: assert property (p_irq)
		else $error("Masked pending flag gave no CPU flag.");
	property p_mask;
		wr_mask |=> radio_event_mask == $past(sfr_wdata);
	endproperty
	a_mask: assert property (p_mask)
		else $error("Mask write not stored.");
	property p_ovf;
		state == ST_RX && rx_byte_valid && data_full && !idle_strobe |=>
			state == ST_RX_OVF && radio_event_flags[BIT_RXOVF] &&
			radio_event_flags[BIT_DONE];
	endproperty
	a_ovf: assert property (p_ovf)
		else $error("Overflow not entered or not flagged.");
	property p_unf;
		enter_unf && !idle_strobe && !cond_rise[BIT_DONE] |=>
			state == ST_TX_UNF && radio_event_flags[BIT_TXUNF] &&
			radio_event_flags[BIT_DONE];
	endproperty
	a_unf: assert property (p_unf)
		else $error("Underflow not entered or not flagged.");
	property p_preamble;
		state == ST_TX_WAIT && !data_full && !wr_data && !idle_strobe
			|=> state == ST_TX_WAIT;
	endproperty
	a_preamble: assert property (p_preamble)
		else $error("Left preamble wait without a byte.");
	property p_stuck;
		(state == ST_RX_OVF || state == ST_TX_UNF) && !idle_strobe
			|=> $stable(state);
	endproperty
	a_stuck: assert property (p_stuck)
		else $error("Error state left without idle strobe.");
	property p_no_request_idle;
		state == ST_IDLE |-> !radio_byte_request_flag;
	endproperty
	a_no_request_idle: assert property (p_no_request_idle)
		else $error("Byte request outside transmit or receive.");
	property p_edge;
		$rose(cond_sync) |=> radio_event_flags[BIT_SFD];
	endproperty
	a_edge: assert property (p_edge)
		else $error("Sync rise did not set its flag.");
	c_ovf: cover property (state == ST_RX ##1 state == ST_RX_OVF);
	c_unf: cover property (state == ST_TX ##1 state == ST_TX_UNF);
	c_take: cover property (tx_byte_take ##[1:200] tx_byte_take);
	c_race: cover property (wr_flags && ev_set != 8'h00);
endmodule
`default_nettype wire

// file: testbench/rdp_cpu_model.sv
// CPU side model that reaches the radio port through the SFR strobes.
// Assumes the bench calls its tasks and shares the system clock.
`timescale 1ns/10ps
`default_nettype none
module rdp_cpu_model (
	input  wire logic       sys_clk,
	input  wire logic [7:0] sfr_rdata,
	output var logic  [7:0] sfr_addr,
	output var logic        sfr_wr,
	output var logic        sfr_rd,
	output var logic  [7:0] sfr_wdata,
	output var logic        idle_strobe
);
	initial begin
		sfr_addr = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_wdata = 8'h00;
		idle_strobe = 1'b0;
	end
	////////////////////////////////////////////////////////////
	task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge sys_clk);
		sfr_wr <= 1'b0;
		// Released data shows the inverse so a stale byte cannot pass.
		sfr_wdata <= ~d;
	endtask
	task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge sys_clk);
		sfr_rd <= 1'b0;
		#1;
		d = sfr_rdata;
	endtask
	task automatic idle_cmd();
		@(posedge sys_clk);
		idle_strobe <= 1'b1;
		@(posedge sys_clk);
		idle_strobe <= 1'b0;
		#1;
	endtask
endmodule
`default_nettype wire

// file: testbench/radio_irq_and_data_port_test.sv
// Self-checking bench for the radio event and data port.
// Assumes the CPU model drives the SFR bus and the idle strobe.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e, m) begin samples_checked++; if ((a) !== (e)) begin \
	bad_count++; $display("FAIL %0t %s", $time, m); end end
module radio_irq_and_data_port_test;
	import rdp_pkg::*;
	localparam int WIN = 1603;
	localparam int LIM = 20000;
	localparam int CAP = WIN / (MIN_SYMBOL_CYCLES << 3);
	logic          sys_clk, sys_rst, sfr_wr, sfr_rd, idle_strobe;
	logic [7:0]    sfr_addr, sfr_wdata, sfr_rdata, rate_m, rx_byte, tx_byte;
	logic [3:0]    rate_e;
	logic [2:0]    clk_speed;
	logic [1:0]    strb;
	logic [5:0]    cond;
	logic          deep_sleep, rx_valid, tx_take, tick, req, irq;
	rdp_state_type radio_state;
	int            bad_count, samples_checked, tick_cnt, cycles, n;
	logic [7:0]    got;
	////////////////////////////////////////////////////////////
	rdp_radio_port dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.transmit_strobe(strb[0]), .receive_strobe(strb[1]),
		.idle_strobe(idle_strobe), .deep_sleep(deep_sleep),
		.rate_mantissa(rate_m), .rate_exponent(rate_e),
		.clk_speed(clk_speed), .rx_byte_valid(rx_valid), .rx_byte(rx_byte),
		.cond_timeout(cond[5]), .cond_packet_end(cond[4]),
		.cond_carrier(cond[3]), .cond_preamble(cond[2]),
		.cond_clear_channel(cond[1]), .cond_sync(cond[0]),
		.tx_byte(tx_byte), .tx_byte_take(tx_take), .symbol_tick(tick),
		.radio_byte_request_flag(req), .cpu_radio_irq_flag(irq),
		.radio_state(radio_state));
	rdp_cpu_model cpu_u (.sys_clk(sys_clk), .sfr_rdata(sfr_rdata),
		.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_wdata(sfr_wdata), .idle_strobe(idle_strobe));
	////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (tick)
			tick_cnt <= tick_cnt + 1;
		cycles <= cycles + 1;
		if (cycles == LIM) begin
			bad_count++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		if (bad_count == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		cpu_u.sfr_write(a, d);
	endtask
	task automatic chk_rd(input logic [7:0] a, input logic [7:0] e,
		input string m);
		cpu_u.sfr_read(a, got);
		`CHK(got, e, m)
	endtask
	task automatic pulse(input logic [1:0] v);
		@(posedge sys_clk);
		strb <= v;
		@(posedge sys_clk);
		strb <= 2'b00;
		#1;
	endtask
	task automatic rx_send(input logic [7:0] b);
		@(posedge sys_clk);
		rx_byte <= b;
		rx_valid <= 1'b1;
		@(posedge sys_clk);
		rx_valid <= 1'b0;
		rx_byte <= ~b;
		#1;
	endtask
	task automatic wait_state(input rdp_state_type s);
		n = 0;
		while (radio_state !== s && n < 1000) begin
			@(negedge sys_clk);
			n++;
		end
		`CHK(radio_state, s, "state wait")
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		{sys_rst, strb, cond, deep_sleep, rx_valid} = 11'h400;
		{rx_byte, bad_count, samples_checked, tick_cnt, cycles} = 0;
		clk_speed = 3'h0;
		rate_m = 8'hFF;
		rate_e = 4'hF;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		chk_rd(ADDR_FLAGS, RESET_BYTE, "flags reset");
		chk_rd(ADDR_MASK, RESET_BYTE, "mask reset");
		chk_rd(8'h12, 8'h00, "unmapped read");
		wr(ADDR_MASK, 8'hA5);
		chk_rd(ADDR_MASK, 8'hA5, "mask rw");
		wr(ADDR_FLAGS, 8'hFF);
		chk_rd(ADDR_FLAGS, 8'h00, "flag set by write");
		for (int i = 0; i < 6; i++) begin
			wr(ADDR_MASK, 8'h00);
			@(posedge sys_clk);
			cond[i] <= 1'b1;
			chk_rd(ADDR_FLAGS, 8'h01 << i, "event flag");
			`CHK(irq, 1'b0, "masked irq")
			wr(ADDR_MASK, 8'h01 << i);
			#1;
			`CHK(irq, 1'b1, "enabled irq")
			wr(ADDR_FLAGS, 8'h00);
			chk_rd(ADDR_FLAGS, 8'h00, "level held");
			cond[i] <= 1'b0;
		end
		// Event rises on the very edge that takes the clearing write.
		fork
			wr(ADDR_FLAGS, 8'h00);
			begin
				@(posedge sys_clk);
				cond[0] <= 1'b1;
			end
		join
		chk_rd(ADDR_FLAGS, 8'h01, "set beats clear");
		cond[0] <= 1'b0;
		wr(ADDR_FLAGS, 8'h00);
		pulse(2'b10);
		`CHK(radio_state, ST_RX, "rx entry")
		`CHK(req, 1'b0, "rx empty req")
		rx_send(8'h5A);
		`CHK(req, 1'b1, "rx req")
		chk_rd(ADDR_DATA, 8'h5A, "rx data");
		`CHK(req, 1'b0, "req after read")
		#1 tick_cnt = 0;
		repeat (WIN) @(posedge sys_clk);
		`CHK(tick_cnt inside {[98:101]}, 1'b1, "tick rate")
		clk_speed <= 3'h3;
		#1 tick_cnt = 0;
		repeat (WIN) @(posedge sys_clk);
		`CHK(tick_cnt inside {[CAP-2:CAP+1]}, 1'b1, "rate cap")
		clk_speed <= 3'h0;
		rx_send(8'h11);
		rx_send(8'h22);
		`CHK(radio_state, ST_RX_OVF, "overflow")
		chk_rd(ADDR_FLAGS, 8'h50, "overflow flags");
		chk_rd(ADDR_DATA, 8'h11, "kept byte");
		`CHK(radio_state, ST_RX_OVF, "stuck overflow")
		cpu_u.idle_cmd();
		`CHK(radio_state, ST_IDLE, "idle exit")
		wr(ADDR_FLAGS, 8'h00);
		pulse(2'b10);
		rx_send(8'h77);
		@(posedge sys_clk) deep_sleep <= 1'b1;
		@(posedge sys_clk) deep_sleep <= 1'b0;
		chk_rd(ADDR_DATA, 8'h00, "sleep byte");
		`CHK(req, 1'b0, "sleep empty")
		cpu_u.idle_cmd();
		`CHK(req, 1'b0, "req before tx")
		wr(ADDR_MASK, 8'h80);
		pulse(2'b01);
		`CHK(radio_state, ST_TX_WAIT, "tx wait")
		`CHK(req, 1'b1, "tx req")
		repeat (300) @(posedge sys_clk);
		#1;
		`CHK(radio_state, ST_TX_WAIT, "preamble")
		chk_rd(ADDR_FLAGS, 8'h00, "no underflow");
		wr(ADDR_DATA, 8'h3C);
		#1;
		`CHK(req, 1'b0, "tx full")
		n = 0;
		while (tx_take !== 1'b1 && n < 400) begin
			@(negedge sys_clk);
			n++;
		end
		`CHK(tx_byte, 8'h3C, "tx byte")
		`CHK(radio_state, ST_TX, "tx run")
		wait_state(ST_TX_UNF);
		`CHK(irq, 1'b1, "underflow irq")
		chk_rd(ADDR_FLAGS, 8'h90, "underflow flags");
		cpu_u.idle_cmd();
		`CHK(radio_state, ST_IDLE, "idle after unf")
		// A rising packet end closes the frame with no underflow.
		wr(ADDR_FLAGS, 8'h00);
		pulse(2'b01);
		wr(ADDR_DATA, 8'hC3);
		wait_state(ST_TX);
		`CHK(tx_byte, 8'hC3, "second tx byte")
		@(posedge sys_clk) cond[4] <= 1'b1;
		@(posedge sys_clk) cond[4] <= 1'b0;
		#1;
		`CHK(radio_state, ST_IDLE, "packet end")
		chk_rd(ADDR_FLAGS, 8'h10, "done flag");
		wrap_up();
	end
endmodule
`default_nettype wire
